/* inc/sqf_pkg.sv */
// package for the serial quad flash interface block
package sqf_pkg;
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h3;
  localparam logic [3:0] ADDR_TX_DATA = 4'h4;
  localparam logic [3:0] ADDR_RX_DATA = 4'h5;
  localparam logic [3:0] ADDR_THRESH = 4'h6;
  localparam logic [3:0] ADDR_MEM_STATUS = 4'h7;
  localparam logic [3:0] ADDR_DMA_EVENT = 4'h8;
  localparam int CTL_CHECK_BIT = 24;
  localparam int CTL_DDR_BIT = 23;
  localparam int CTL_RELEASE_BIT = 22;
  localparam int IRQ_DMA_ERR = 11;
  localparam int IRQ_PKT_DONE = 10;
  localparam int IRQ_DESC_DONE = 9;
  localparam int IRQ_CTRL_THR = 8;
  localparam int IRQ_CTRL_EMPTY = 7;
  localparam int IRQ_CTRL_FULL = 6;
  localparam int IRQ_RX_THR = 5;
  localparam int IRQ_RX_FULL = 4;
  localparam int IRQ_RX_EMPTY = 3;
  localparam int IRQ_TX_THR = 2;
  localparam int IRQ_TX_FULL = 1;
  localparam int IRQ_TX_EMPTY = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [11:0] IRQ_STATUS_RESET = 12'h0ad;
  localparam logic [11:0] IRQ_ENABLE_RESET = 12'h000;
  localparam logic [3:0] BUF_DEPTH = 4'h8;
  localparam logic [7:0] MEM_STATUS_RESET = 8'h00;
  localparam logic [15:0] MEM_CHECK_CMD = 16'h0005;
  typedef enum logic [1:0] {SQF_LANE_ONE, SQF_LANE_TWO, SQF_LANE_FOUR, SQF_LANE_RSV}
    sqf_lane_type;
  typedef enum logic [1:0] {SQF_CMD_IDLE, SQF_CMD_TX, SQF_CMD_RX, SQF_CMD_RSV} sqf_cmd_type;
  typedef struct packed {
    logic [6:0] unused;
    logic status_check_en;
    logic double_rate_sel;
    logic cs_release_en;
    logic [1:0] target_device_sel;
    sqf_lane_type lane_width_sel;
    sqf_cmd_type command_start_mode;
    logic [15:0] transfer_byte_count;
  } sqf_control_type;
endpackage

/* rtl/sqf_top.sv */
// serial quad flash controller: registers, byte engine, flags
// Function
// - status check enable in receive mode runs a status poll using the memory status register
// - ddr select shifts on both link edges, else one edge
// - release enable drops chip select after the byte count completes
// - device select 00 picks flash 0, 01 flash 1, others reserved
// - lane select 00 one, 01 two, 10 four lanes, 11 reserved
// - transmit mode starts on transmit write or buffered transmit data
// - receive mode starts on receive read or receive buffer space
// - sixteen bit count gives bytes moved in the chosen direction
// - hardware sets flags; only writing one clears them
// - descriptor dma bus error sets its flag
// - packet completion sets the packet flag
// - descriptor processing done sets its flag
// - control buffer free space above threshold sets threshold flag
// - control buffer empty and full set their flags
// - receive free space above threshold sets receive threshold flag
// - receive buffer full and empty set their flags
// - receive threshold flag reads set from reset till first read
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module sqf_top
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic link_clk,
  output logic [1:0] flash_cs_n,
  input wire logic [3:0] flash_dq_in,
  output logic [3:0] flash_dq_out,
  output logic [3:0] flash_dq_oe
);
  sqf_pkg::sqf_control_type control;
  logic [11:0] irq_status;
  logic [11:0] irq_enable;
  logic [7:0] tx_buf [8];
  logic [7:0] rx_buf [8];
  logic [3:0] tx_count;
  logic [3:0] rx_count;
  logic [2:0] tx_rd;
  logic [2:0] tx_wr;
  logic [2:0] rx_rd;
  logic [2:0] rx_wr;
  logic [3:0] rx_threshold;
  logic [3:0] ctrl_threshold;
  logic [7:0] mem_status;
  logic rx_seen_read;
  logic [2:0] link_sync;
  logic [7:0] shift;
  logic [3:0] bits_left;
  logic [15:0] bytes_left;
  logic busy;
  logic checking;
  logic cs_on;
  logic tx_kick;
  logic rx_kick;
  logic [11:0] events;
  logic [2:0] dma_event;
  logic [3:0] dq_in_s1;
  logic [3:0] dq_in_s2;

  function automatic logic [3:0] lane_bits(input sqf_pkg::sqf_lane_type l);
    unique case (l)
      sqf_pkg::SQF_LANE_ONE: lane_bits = 4'h1;
      sqf_pkg::SQF_LANE_TWO: lane_bits = 4'h2;
      sqf_pkg::SQF_LANE_FOUR: lane_bits = 4'h4;
      default: lane_bits = 4'h0;
    endcase
  endfunction

  wire is_write = reg_write;
  wire is_read = reg_read;
  wire wr_ctl = is_write && reg_addr == sqf_pkg::ADDR_CONTROL;
  wire wr_clr = is_write && reg_addr == sqf_pkg::ADDR_IRQ_CLEAR;
  wire wr_en = is_write && reg_addr == sqf_pkg::ADDR_IRQ_ENABLE;
  wire wr_tx = is_write && reg_addr == sqf_pkg::ADDR_TX_DATA;
  wire wr_thr = is_write && reg_addr == sqf_pkg::ADDR_THRESH;
  wire wr_mem = is_write && reg_addr == sqf_pkg::ADDR_MEM_STATUS;
  wire wr_dma = is_write && reg_addr == sqf_pkg::ADDR_DMA_EVENT;
  wire rd_rx = is_read && reg_addr == sqf_pkg::ADDR_RX_DATA;
  wire [3:0] step = lane_bits(control.lane_width_sel);
  // reserved device, lane or command codes never start anything
  wire codes_ok = !control.target_device_sel[1] && step != 4'h0 &&
    control.command_start_mode != sqf_pkg::SQF_CMD_RSV;
  wire link_rise = link_sync[1] && !link_sync[2];
  wire link_fall = !link_sync[1] && link_sync[2];
  // ddr uses both edges of the link clock
  wire link_tick = link_rise || (control.double_rate_sel && link_fall);
  wire tx_mode = control.command_start_mode == sqf_pkg::SQF_CMD_TX;
  wire rx_mode = control.command_start_mode == sqf_pkg::SQF_CMD_RX;
  wire start_tx = codes_ok && tx_mode && (tx_kick || tx_count != 4'h0);
  wire start_rx = codes_ok && rx_mode && (rx_kick || rx_count != sqf_pkg::BUF_DEPTH);
  wire start_ok = !busy && control.transfer_byte_count != 16'h0000 && (start_tx || start_rx);
  wire byte_end = busy && link_tick && bits_left <= step;
  wire last_byte = byte_end && bytes_left == 16'h0001;
  wire need_tx_byte = busy && tx_mode && bits_left == 4'h0 && tx_count != 4'h0;
  wire push_rx = byte_end && rx_mode && rx_count != sqf_pkg::BUF_DEPTH;
  wire [7:0] rx_byte = (step == 4'h1) ? {shift[6:0], dq_in_s2[1]} :
    (step == 4'h2) ? {shift[5:0], dq_in_s2[1:0]} : {shift[3:0], dq_in_s2};
  wire push_tx = wr_tx && tx_count != sqf_pkg::BUF_DEPTH;
  wire pop_rx = rd_rx && rx_count != 4'h0;
  wire [3:0] tx_free = sqf_pkg::BUF_DEPTH - tx_count;
  wire [3:0] rx_free = sqf_pkg::BUF_DEPTH - rx_count;
  // command queue is the transmit queue; it shares its occupancy
  wire [3:0] ctrl_free = tx_free;

  assign events[sqf_pkg::IRQ_DMA_ERR] = dma_event[0];
  assign events[sqf_pkg::IRQ_PKT_DONE] = dma_event[1] || last_byte;
  assign events[sqf_pkg::IRQ_DESC_DONE] = dma_event[2];
  assign events[sqf_pkg::IRQ_CTRL_THR] = ctrl_free > ctrl_threshold;
  assign events[sqf_pkg::IRQ_CTRL_EMPTY] = tx_count == 4'h0;
  assign events[sqf_pkg::IRQ_CTRL_FULL] = tx_count == sqf_pkg::BUF_DEPTH;
  // threshold stays hot from reset until the first receive read
  assign events[sqf_pkg::IRQ_RX_THR] = !rx_seen_read || rx_free > rx_threshold;
  assign events[sqf_pkg::IRQ_RX_FULL] = rx_count == sqf_pkg::BUF_DEPTH;
  assign events[sqf_pkg::IRQ_RX_EMPTY] = rx_count == 4'h0;
  assign events[sqf_pkg::IRQ_TX_THR] = tx_free > rx_threshold;
  assign events[sqf_pkg::IRQ_TX_FULL] = tx_count == sqf_pkg::BUF_DEPTH;
  assign events[sqf_pkg::IRQ_TX_EMPTY] = tx_count == 4'h0;

  wire [11:0] next_irq_status = (irq_status & ~(wr_clr ? reg_wdata[11:0] : 12'h000)) |
    events;
  wire [31:0] read_mux =
    (reg_addr == sqf_pkg::ADDR_CONTROL) ? control :
    (reg_addr == sqf_pkg::ADDR_IRQ_STATUS) ? {20'h00000, irq_status} :
    (reg_addr == sqf_pkg::ADDR_IRQ_ENABLE) ? {20'h00000, irq_enable} :
    (reg_addr == sqf_pkg::ADDR_RX_DATA) ? {24'h000000, rx_buf[rx_rd]} :
    (reg_addr == sqf_pkg::ADDR_THRESH) ? {24'h000000, ctrl_threshold, rx_threshold} :
    (reg_addr == sqf_pkg::ADDR_MEM_STATUS) ?
      {15'h0000, busy, checking, cs_on, 6'h00, mem_status} : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      control <= sqf_pkg::CONTROL_RESET;
      irq_enable <= sqf_pkg::IRQ_ENABLE_RESET;
      rx_threshold <= 4'h0;
      ctrl_threshold <= 4'h0;
      mem_status <= sqf_pkg::MEM_STATUS_RESET;
      dma_event <= 3'h0;
    end
    else
    begin
      if (wr_ctl)
        control <= {7'h00, reg_wdata[24:0]};
      if (wr_en)
        irq_enable <= reg_wdata[11:0];
      if (wr_thr)
        {ctrl_threshold, rx_threshold} <= reg_wdata[7:0];
      if (wr_mem)
        mem_status <= reg_wdata[7:0];
      else if (checking && push_rx)
        mem_status <= rx_byte;
      // dma engine lives outside; its events arrive as a write here
      dma_event <= wr_dma ? reg_wdata[2:0] : 3'h0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_status <= sqf_pkg::IRQ_STATUS_RESET;
      irq <= 1'b0;
      reg_rdata <= 32'h0000_0000;
      rx_seen_read <= 1'b0;
      tx_kick <= 1'b0;
      rx_kick <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_enable);
      reg_rdata <= is_read ? read_mux : 32'h0000_0000;
      if (rd_rx)
        rx_seen_read <= 1'b1;
      tx_kick <= wr_tx ? 1'b1 : (start_ok ? 1'b0 : tx_kick);
      rx_kick <= rd_rx ? 1'b1 : (start_ok ? 1'b0 : rx_kick);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link_sync <= 3'h0;
      dq_in_s1 <= 4'h0;
      dq_in_s2 <= 4'h0;
    end
    else
    begin
      link_sync <= {link_sync[1:0], link_clk};
      dq_in_s1 <= flash_dq_in;
      dq_in_s2 <= dq_in_s1;
    end
  end

  // eight-entry queues; counts give honest full and empty
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_count <= 4'h0;
      rx_count <= 4'h0;
      tx_rd <= 3'h0;
      tx_wr <= 3'h0;
      rx_rd <= 3'h0;
      rx_wr <= 3'h0;
    end
    else
    begin
      if (push_tx)
      begin
        tx_wr <= tx_wr + 3'h1;
      end
      if (need_tx_byte)
        tx_rd <= tx_rd + 3'h1;
      tx_count <= tx_count + {3'h0, push_tx} - {3'h0, need_tx_byte};
      if (push_rx && !checking)
      begin
        rx_wr <= rx_wr + 3'h1;
      end
      if (pop_rx)
        rx_rd <= rx_rd + 3'h1;
      rx_count <= rx_count + {3'h0, push_rx && !checking} - {3'h0, pop_rx};
    end
  end

  // queue storage has no reset so it can map onto plain memory
  always_ff @(posedge clk)
  begin
    if (push_tx)
      tx_buf[tx_wr] <= reg_wdata[7:0];
    if (push_rx && !checking)
      rx_buf[rx_wr] <= rx_byte;
  end

  // transfer engine; transmit waits for data rather than sending stale bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      checking <= 1'b0;
      cs_on <= 1'b0;
      shift <= 8'h00;
      bits_left <= 4'h0;
      bytes_left <= 16'h0000;
    end
    else if (start_ok)
    begin
      busy <= 1'b1;
      cs_on <= 1'b1;
      checking <= control.status_check_en && rx_mode;
      bytes_left <= control.transfer_byte_count;
      bits_left <= rx_mode ? 4'h8 : 4'h0;
    end
    else if (need_tx_byte)
    begin
      shift <= tx_buf[tx_rd];
      bits_left <= 4'h8;
    end
    else if (busy && link_tick && bits_left != 4'h0)
    begin
      shift <= rx_mode ? rx_byte : shift << step;
      bits_left <= byte_end ? (rx_mode ? 4'h8 : 4'h0) : bits_left - step;
      if (byte_end)
        bytes_left <= bytes_left - 16'h0001;
      if (last_byte)
      begin
        busy <= 1'b0;
        checking <= 1'b0;
        cs_on <= !control.cs_release_en;
      end
    end
    else if (!busy && wr_ctl && reg_wdata[sqf_pkg::CTL_RELEASE_BIT])
      cs_on <= 1'b0;
  end

  // chip select goes to the chosen flash only
  assign flash_cs_n = {!(cs_on && control.target_device_sel == 2'b01),
    !(cs_on && control.target_device_sel == 2'b00)};
  wire driving = busy && tx_mode && bits_left != 4'h0;
  assign flash_dq_oe = driving ? ((step == 4'h1) ? 4'h1 :
    (step == 4'h2) ? 4'h3 : 4'hf) : 4'h0;
  assign flash_dq_out = (step == 4'h1) ? {3'h0, shift[7]} :
    (step == 4'h2) ? {2'h0, shift[7:6]} : shift[7:4];
endmodule

/* testbench/sqf_top_properties.sv */
// port checks for the serial quad flash controller
`timescale 1ns/1ps
module sqf_checker
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  input wire logic [1:0] flash_cs_n,
  input wire logic [3:0] flash_dq_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence set_err;
    reg_write && reg_addr == sqf_pkg::ADDR_DMA_EVENT && reg_wdata[0];
  endsequence
  sequence clr_err;
    reg_write && reg_addr == sqf_pkg::ADDR_IRQ_CLEAR && reg_wdata[sqf_pkg::IRQ_DMA_ERR];
  endsequence
  // a write in the gap could legally change the flag, so demand a quiet cycle
  sequence read_stat;
    !reg_write ##1 reg_read && reg_addr == sqf_pkg::ADDR_IRQ_STATUS;
  endsequence
  chk_err_sets: assert property (set_err ##1 read_stat |=> reg_rdata[11])
    else $error("bus error event not seen in status");
  chk_clear_one: assert property (clr_err ##1 read_stat |=> !reg_rdata[11])
    else $error("status bit survived a write of one");
  chk_status_upper: assert property (reg_read && reg_addr == sqf_pkg::ADDR_IRQ_STATUS
    |=> reg_rdata[31:12] == 20'h0) else $error("status upper bits not zero");
  chk_ctrl_readback: assert property (reg_read && reg_addr == sqf_pkg::ADDR_CONTROL
    && $past(reg_write, 2) && $past(reg_addr, 2) == sqf_pkg::ADDR_CONTROL && !$past(reg_write)
    |=> reg_rdata == ($past(reg_wdata, 3) & 32'h01ff_ffff)) else $error("control readback");
  chk_single_select: assert property (flash_cs_n != 2'b00)
    else $error("both flash devices selected");
  chk_oe_lanes: assert property (flash_dq_oe inside {4'h0, 4'h1, 4'h3, 4'hf})
    else $error("output enable pattern is no lane width");
  chk_oe_selected: assert property (|flash_dq_oe |-> flash_cs_n != 2'b11)
    else $error("data driven with no device selected");
  chk_irq_masked: assert property (reg_write && reg_addr == sqf_pkg::ADDR_IRQ_ENABLE
    && reg_wdata[11:0] == 12'h000 ##1 !(reg_write && reg_addr == sqf_pkg::ADDR_IRQ_ENABLE)
    |=> !irq) else $error("interrupt high with all enables off");
endmodule

/* testbench/sqf_flash_model.sv */
// flash partner: sends a fixed byte when read, records written bits
`timescale 1ns/1ps
module sqf_flash_model
#(
  parameter logic [7:0] READ_BYTE = 8'h3c
)
(
  input wire logic link_clk,
  input wire logic [1:0] cs_n,
  input wire logic [3:0] dq_out,
  output logic [3:0] dq_in,
  output logic [7:0] got,
  output logic [7:0] got_both
);
  logic [7:0] sh = READ_BYTE;
  logic noise = 1'b0;
  logic [7:0] rise_sh = 8'h00;
  logic [7:0] edge_sh = 8'h00;
  // single lane answers on lane 1; other lanes toggle so a stale level never passes
  assign dq_in = {noise, noise, sh[7], ~noise};
  assign got = rise_sh;
  assign got_both = edge_sh;
  // byte reloads while device 0 is deselected, so each frame starts at its top bit
  always @(negedge link_clk or posedge cs_n[0])
  begin
    noise <= ~noise;
    if (cs_n[0])
      sh <= READ_BYTE;
    else if (cs_n == 2'b10)
      sh <= {sh[6:0], sh[7]};
  end
  always @(posedge link_clk)
    if (cs_n == 2'b01)
      rise_sh <= {rise_sh[6:0], dq_out[0]};
  // double rate takes a bit on both link edges
  always @(link_clk)
    if (cs_n == 2'b01)
      edge_sh <= {edge_sh[6:0], dq_out[0]};
endmodule

/* testbench/quad_serial_flash_interface_tb_top.sv */
// bench for the serial quad flash controller
`timescale 1ns/1ps
module quad_serial_flash_interface_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link_clk = 1'b0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  logic irq;
  logic [1:0] flash_cs_n;
  logic [3:0] flash_dq_in;
  logic [3:0] flash_dq_out;
  logic [3:0] flash_dq_oe;
  logic [7:0] got;
  logic [7:0] got_both;
  int cs_age = 0;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // control word written, control word read back; command field idle
  logic [31:0] rows [5][2] = '{'{32'h0180_0001, 32'h0180_0001},
    '{32'h0074_ffff, 32'h0074_ffff}, '{32'h0028_1234, 32'h0028_1234},
    '{32'h001c_8000, 32'h001c_8000}, '{32'hfc00_0000, 32'h0000_0000}};
  sqf_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .link_clk(link_clk), .flash_cs_n(flash_cs_n), .flash_dq_in(flash_dq_in),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
  sqf_flash_model flash (.link_clk(link_clk), .cs_n(flash_cs_n), .dq_out(flash_dq_out),
    .dq_in(flash_dq_in), .got(got), .got_both(got_both));
  always #12.5 clk = ~clk;
  // link runs only inside frames and starts some cycles after select,
  // so the first transmit byte is loaded before the first link edge
  always @(posedge clk)
    cs_age <= (flash_cs_n == 2'b11) ? 0 : cs_age + 1;
  initial
  begin
    #7;
    forever #100 link_clk <= (cs_age > 3) ? ~link_clk : 1'b0;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // bounded wait, a hung transfer shows up as a mismatch
  task automatic wait_cs(input logic [1:0] v);
    int n = 0;
    while (flash_cs_n !== v && n < 400)
    begin
      @(posedge clk);
      #1 n++;
    end
    check({30'h0, flash_cs_n}, {30'h0, v});
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      results;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(sqf_pkg::ADDR_IRQ_STATUS, rd_val);
    // free control space above a zero threshold sets its flag on the first clock
    check(rd_val, {20'h0, sqf_pkg::IRQ_STATUS_RESET | (12'h001 << sqf_pkg::IRQ_CTRL_THR)});
    rd(sqf_pkg::ADDR_CONTROL, rd_val);
    check(rd_val, sqf_pkg::CONTROL_RESET);
    rd(4'hf, rd_val);
    check(rd_val, 32'h0);
    check({30'h0, flash_cs_n}, 32'h3);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(sqf_pkg::ADDR_CONTROL, rows[i][0]);
      rd(sqf_pkg::ADDR_CONTROL, rd_val);
      check(rd_val, rows[i][1]);
    end
    $display("control test done");
    for (int i = 0; i < 3; i++)
    begin
      wr(sqf_pkg::ADDR_DMA_EVENT, 32'h1 << i);
      rd(sqf_pkg::ADDR_IRQ_STATUS, rd_val);
      check((rd_val >> (11 - i)) & 32'h1, 32'h1);
      wr(sqf_pkg::ADDR_IRQ_CLEAR, 32'h0);
      wr(sqf_pkg::ADDR_IRQ_ENABLE, 32'h800 >> i);
      @(posedge clk);
      #1 check({31'h0, irq}, 32'h1);
      wr(sqf_pkg::ADDR_IRQ_ENABLE, 32'h0);
      @(posedge clk);
      #1 check({31'h0, irq}, 32'h0);
      wr(sqf_pkg::ADDR_IRQ_CLEAR, 32'h800 >> i);
      rd(sqf_pkg::ADDR_IRQ_STATUS, rd_val);
      check((rd_val >> (11 - i)) & 32'h1, 32'h0);
    end
    $display("event test done");
    wr(sqf_pkg::ADDR_IRQ_CLEAR, 32'hfff);
    wr(sqf_pkg::ADDR_CONTROL, 32'h0051_0001);
    wr(sqf_pkg::ADDR_TX_DATA, 32'ha5);
    wait_cs(2'b01);
    wait_cs(2'b11);
    check({24'h0, got}, 32'ha5);
    rd(sqf_pkg::ADDR_IRQ_STATUS, rd_val);
    check(rd_val & 32'h400, 32'h400);
    wr(sqf_pkg::ADDR_CONTROL, 32'h00d1_0001);
    wr(sqf_pkg::ADDR_TX_DATA, 32'hc3);
    wait_cs(2'b01);
    wait_cs(2'b11);
    check({24'h0, got_both}, 32'hc3);
    $display("transmit test done");
    wr(sqf_pkg::ADDR_CONTROL, 32'h0142_0001);
    wait_cs(2'b10);
    wait_cs(2'b11);
    // receive restarts while space is free; idle with release ends the stream
    wr(sqf_pkg::ADDR_CONTROL, 32'h0040_0000);
    wait_cs(2'b11);
    rd(sqf_pkg::ADDR_MEM_STATUS, rd_val);
    check(rd_val & 32'hff, 32'h3c);
    wr(sqf_pkg::ADDR_CONTROL, 32'h0042_0001);
    wait_cs(2'b10);
    wait_cs(2'b11);
    wr(sqf_pkg::ADDR_CONTROL, 32'h0040_0000);
    wait_cs(2'b11);
    rd(sqf_pkg::ADDR_RX_DATA, rd_val);
    check(rd_val & 32'hff, 32'h3c);
    $display("receive test done");
    wr(sqf_pkg::ADDR_CONTROL, 32'h0061_0001);
    wr(sqf_pkg::ADDR_TX_DATA, 32'h5a);
    repeat (100) @(posedge clk);
    #1 check({26'h0, flash_dq_oe, flash_cs_n}, 32'h3);
    $display("reserved test done");
    results;
  end
endmodule
bind sqf_top sqf_checker chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .irq(irq), .flash_cs_n(flash_cs_n), .flash_dq_oe(flash_dq_oe));
